/* File: core/sled_core.sv */
// Front-panel status indicator pattern generator with a Wishbone register slave.
// Assumes firmware keeps the condition register current and LINK_UP and FRAME_ACT
// are synchronous to CLK.
//
// Operation
// R1: System indicator steady green while the operating system runs.
// R2: System indicator steady yellow before the operating system runs; stuck yellow means hardware fault.
// R3: Boot loader error flashes the system indicator yellow and green alternately.
// R4: Application indicator steady green when both ports cyclic and gateway executing.
// R5: First port not cyclic: green, 2 s dark then 0.5 s lit, repeated.
// R6: Second port not cyclic: green double blink, 2 s dark, lit, dark, lit.
// R7: First port configuration bad: red, 2 s dark then 0.5 s lit.
// R8: Second port configuration bad: red double blink with 0.5 s steps.
// R9: Initialisation error: application indicator steady red.
// R10: Module state indicator steady green when operating correctly.
// R11: Module state indicator flashes green while not configured.
// R12: Major fault: module state indicator steady red.
// R13: Minor fault or bad configuration: module state indicator flashes red.
// R14: Self-test: module state indicator flashes green and red alternately.
// R15: Connection established: network state indicator steady green.
// R16: No connection but address obtained: network state indicator flashes green.
// R17: Duplicate address detected: network state indicator steady red.
// R18: Connection timed out: network state indicator flashes red until cleared or reset.
// R19: Self-test: network state indicator flashes green and red alternately.
// R20: Network state indicator dark without an address.
// R21: Link indicator lit while an Ethernet link is present.
// R22: Activity indicator flashes while frames are sent or received.
// R23: Application priority: steady red, configuration errors, not cyclic, first port first.
// R24: Module and network flashing uses a 1 Hz square wave from clock counting.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
module sled_core
#(
    parameter int HALF_CYC = sled_pkg::HALF_SEC_CYC,
    parameter int ACT_CYC = sled_pkg::ACT_FLASH_CYC
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic LINK_UP,
    input wire logic FRAME_ACT,
    output logic SYS_GREEN,
    output logic SYS_YELLOW,
    output logic APP_GREEN,
    output logic APP_RED,
    output logic MOD_GREEN,
    output logic MOD_RED,
    output logic NET_GREEN,
    output logic NET_RED,
    output logic LINK_GREEN,
    output logic ACT_YELLOW
);
    import sled_pkg::*;

    // ---------------------------------------------------------------
    // Parameter checks
    // ---------------------------------------------------------------
    generate
        if (HALF_CYC < 2 || ACT_CYC < 1)
        begin : g_bad_param
            $error("HALF_CYC must be at least 2 and ACT_CYC at least 1");
        end
    endgenerate

    localparam int TICK_W = $clog2(HALF_CYC);
    localparam int ACT_W = $clog2(2 * ACT_CYC + 1);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [TICK_W-1:0] tick_cnt;
        logic [2:0] ph5;
        logic [2:0] ph7;
        logic flash;
        logic [ACT_W-1:0] act_cnt;
        sled_app_e app_mode;
        logic [LED_W-1:0] led;
        logic ack;
        logic [31:0] dat;
    } sled_state_s;

    sled_state_s s_r;
    sled_state_s s_nxt;
    logic tick;
    logic req;
    logic [31:0] wmask;
    logic [31:0] ctrl_wide;
    logic [2:0] app_sel;
    logic app_lit;

    assign tick = (s_r.tick_cnt == TICK_W'(HALF_CYC - 1));
    assign req = WB_CYC_I && WB_STB_I && !s_r.ack;
    assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign ctrl_wide = {{(32 - CTRL_W){1'b0}}, s_r.ctrl};

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        app_sel = 3'b000;
        app_lit = 1'b0;

        // Wishbone slave: one-cycle answer, unmapped reads return zero.
        s_nxt.ack = req;
        if (req && WB_WE_I && WB_ADR_I == CTRL_ADDR)
        begin
            s_nxt.ctrl = CTRL_W'((ctrl_wide & ~wmask) | (WB_DAT_I & wmask));
        end
        if (req && !WB_WE_I)
        begin
            if (WB_ADR_I == CTRL_ADDR)
            begin
                s_nxt.dat = ctrl_wide;
            end
            else if (WB_ADR_I == STATE_ADDR)
            begin
                s_nxt.dat = {17'h0_0000, s_r.app_mode, 2'b00, s_r.led};
            end
            else
            begin
                s_nxt.dat = 32'h0000_0000;
            end
        end

        // Half-second time base and pattern phases.
        if (tick)
        begin
            s_nxt.tick_cnt = '0;
            s_nxt.flash = !s_r.flash; // [R24]
            s_nxt.ph5 = (s_r.ph5 == 3'(SINGLE_TICKS - 1)) ? 3'h0 : s_r.ph5 + 3'h1;
            s_nxt.ph7 = (s_r.ph7 == 3'(DOUBLE_TICKS - 1)) ? 3'h0 : s_r.ph7 + 3'h1;
        end
        else
        begin
            s_nxt.tick_cnt = s_r.tick_cnt + TICK_W'(1);
        end

        // Application pattern selection in priority order.
        if (s_r.ctrl[INIT_ERROR_BIT])
        begin
            s_nxt.app_mode = SLED_APP_RED_ON; // [R9] [R23]
        end
        else if (!s_r.ctrl[INIT_DONE_BIT])
        begin
            s_nxt.app_mode = SLED_APP_OFF;
        end
        else if (s_r.ctrl[P1_CFG_ERR_BIT])
        begin
            s_nxt.app_mode = SLED_APP_RED_1; // [R7] [R23]
        end
        else if (s_r.ctrl[P2_CFG_ERR_BIT])
        begin
            s_nxt.app_mode = SLED_APP_RED_2; // [R8] [R23]
        end
        else if (!s_r.ctrl[P1_CYCLIC_BIT])
        begin
            s_nxt.app_mode = SLED_APP_GRN_1; // [R5] [R23]
        end
        else if (!s_r.ctrl[P2_CYCLIC_BIT])
        begin
            s_nxt.app_mode = SLED_APP_GRN_2; // [R6] [R23]
        end
        else if (s_r.ctrl[GW_EXEC_BIT])
        begin
            s_nxt.app_mode = SLED_APP_GRN_ON; // [R4]
        end
        else
        begin
            s_nxt.app_mode = SLED_APP_OFF;
        end

        // Blink envelopes: four dark steps, then lit (single) or lit, dark, lit (double).
        case (s_r.app_mode)
            SLED_APP_RED_ON:
            begin
                app_sel = 3'b010;
                app_lit = 1'b1;
            end
            SLED_APP_RED_1:
            begin
                app_sel = 3'b010;
                app_lit = (s_r.ph5 == 3'(DARK_TICKS)); // [R7]
            end
            SLED_APP_RED_2:
            begin
                app_sel = 3'b010;
                app_lit = (s_r.ph7 == 3'(DARK_TICKS)) || (s_r.ph7 == 3'(DARK_TICKS + 2)); // [R8]
            end
            SLED_APP_GRN_1:
            begin
                app_sel = 3'b001;
                app_lit = (s_r.ph5 == 3'(DARK_TICKS)); // [R5]
            end
            SLED_APP_GRN_2:
            begin
                app_sel = 3'b001;
                app_lit = (s_r.ph7 == 3'(DARK_TICKS)) || (s_r.ph7 == 3'(DARK_TICKS + 2)); // [R6]
            end
            SLED_APP_GRN_ON:
            begin
                app_sel = 3'b001;
                app_lit = 1'b1;
            end
            default:
            begin
                app_sel = 3'b000;
                app_lit = 1'b0;
            end
        endcase
        s_nxt.led[APP_GREEN_BIT] = app_sel[0] && app_lit;
        s_nxt.led[APP_RED_BIT] = app_sel[1] && app_lit;

        // System indicator.
        if (s_r.ctrl[BOOT_ERROR_BIT])
        begin
            s_nxt.led[SYS_GREEN_BIT] = s_r.flash; // [R3]
            s_nxt.led[SYS_YELLOW_BIT] = !s_r.flash; // [R3]
        end
        else if (s_r.ctrl[OS_RUNNING_BIT])
        begin
            s_nxt.led[SYS_GREEN_BIT] = 1'b1; // [R1]
            s_nxt.led[SYS_YELLOW_BIT] = 1'b0;
        end
        else
        begin
            s_nxt.led[SYS_GREEN_BIT] = 1'b0;
            s_nxt.led[SYS_YELLOW_BIT] = 1'b1; // [R2]
        end

        // Module state indicator.
        if (s_r.ctrl[SELF_TEST_BIT])
        begin
            s_nxt.led[MOD_GREEN_BIT] = s_r.flash; // [R14]
            s_nxt.led[MOD_RED_BIT] = !s_r.flash; // [R14]
        end
        else if (s_r.ctrl[MAJOR_FAULT_BIT])
        begin
            s_nxt.led[MOD_GREEN_BIT] = 1'b0;
            s_nxt.led[MOD_RED_BIT] = 1'b1; // [R12]
        end
        else if (s_r.ctrl[MINOR_FAULT_BIT])
        begin
            s_nxt.led[MOD_GREEN_BIT] = 1'b0;
            s_nxt.led[MOD_RED_BIT] = s_r.flash; // [R13] [R24]
        end
        else if (s_r.ctrl[CONFIGURED_BIT])
        begin
            s_nxt.led[MOD_GREEN_BIT] = 1'b1; // [R10]
            s_nxt.led[MOD_RED_BIT] = 1'b0;
        end
        else
        begin
            s_nxt.led[MOD_GREEN_BIT] = s_r.flash; // [R11] [R24]
            s_nxt.led[MOD_RED_BIT] = 1'b0;
        end

        // Network state indicator.
        if (s_r.ctrl[SELF_TEST_BIT])
        begin
            s_nxt.led[NET_GREEN_BIT] = s_r.flash; // [R19]
            s_nxt.led[NET_RED_BIT] = !s_r.flash; // [R19]
        end
        else if (!s_r.ctrl[IP_VALID_BIT])
        begin
            s_nxt.led[NET_GREEN_BIT] = 1'b0; // [R20]
            s_nxt.led[NET_RED_BIT] = 1'b0; // [R20]
        end
        else if (s_r.ctrl[DUP_IP_BIT])
        begin
            s_nxt.led[NET_GREEN_BIT] = 1'b0;
            s_nxt.led[NET_RED_BIT] = 1'b1; // [R17]
        end
        else if (s_r.ctrl[CONN_TIMEOUT_BIT])
        begin
            s_nxt.led[NET_GREEN_BIT] = 1'b0;
            s_nxt.led[NET_RED_BIT] = s_r.flash; // [R18] [R24]
        end
        else if (s_r.ctrl[CONNECTED_BIT])
        begin
            s_nxt.led[NET_GREEN_BIT] = 1'b1; // [R15]
            s_nxt.led[NET_RED_BIT] = 1'b0;
        end
        else
        begin
            s_nxt.led[NET_GREEN_BIT] = s_r.flash; // [R16] [R24]
            s_nxt.led[NET_RED_BIT] = 1'b0;
        end

        // Link follows the PHY; activity is stretched into a lit then dark period per burst.
        s_nxt.led[LINK_BIT] = LINK_UP; // [R21]
        if (s_r.act_cnt != '0)
        begin
            s_nxt.act_cnt = s_r.act_cnt - ACT_W'(1);
        end
        else if (FRAME_ACT)
        begin
            s_nxt.act_cnt = ACT_W'(2 * ACT_CYC); // [R22]
        end
        s_nxt.led[ACT_BIT] = (s_r.act_cnt > ACT_W'(ACT_CYC)); // [R22]
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            s_r.ctrl <= CTRL_RESET;
            s_r.tick_cnt <= '0;
            s_r.ph5 <= 3'h0;
            s_r.ph7 <= 3'h0;
            s_r.flash <= 1'b0;
            s_r.act_cnt <= '0;
            s_r.app_mode <= SLED_APP_OFF;
            s_r.led <= '0;
            s_r.ack <= 1'b0;
            s_r.dat <= 32'h0000_0000;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign WB_ACK_O = s_r.ack;
    assign WB_DAT_O = s_r.dat;
    assign SYS_GREEN = s_r.led[SYS_GREEN_BIT];
    assign SYS_YELLOW = s_r.led[SYS_YELLOW_BIT];
    assign APP_GREEN = s_r.led[APP_GREEN_BIT];
    assign APP_RED = s_r.led[APP_RED_BIT];
    assign MOD_GREEN = s_r.led[MOD_GREEN_BIT];
    assign MOD_RED = s_r.led[MOD_RED_BIT];
    assign NET_GREEN = s_r.led[NET_GREEN_BIT];
    assign NET_RED = s_r.led[NET_RED_BIT];
    assign LINK_GREEN = s_r.led[LINK_BIT];
    assign ACT_YELLOW = s_r.led[ACT_BIT];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence app_red_single_s;
        s_r.app_mode == SLED_APP_RED_1 && s_r.ph5 == 3'(DARK_TICKS);
    endsequence
    sequence app_grn_double_dark_s;
        s_r.app_mode == SLED_APP_GRN_2 && s_r.ph7 == 3'(DARK_TICKS + 1);
    endsequence

    sys_green_run_a: assert property ( // [R1]
        s_r.ctrl[OS_RUNNING_BIT] && !s_r.ctrl[BOOT_ERROR_BIT] |=> SYS_GREEN && !SYS_YELLOW)
        else $error("system indicator not green while running");
    sys_boot_alt_a: assert property ( // [R3]
        s_r.ctrl[BOOT_ERROR_BIT] |=> SYS_GREEN != SYS_YELLOW && SYS_GREEN == $past(s_r.flash))
        else $error("boot error flash wrong");
    app_red_blink_a: assert property ( // [R7]
        app_red_single_s |=> APP_RED && !APP_GREEN)
        else $error("red single blink not lit");
    app_dbl_dark_a: assert property ( // [R6]
        app_grn_double_dark_s |=> !APP_GREEN && !APP_RED)
        else $error("double blink gap not dark");
    app_priority_a: assert property ( // [R23]
        s_r.ctrl[INIT_ERROR_BIT] |=> s_r.app_mode == SLED_APP_RED_ON ##1 APP_RED)
        else $error("init error not shown first");
    flash_toggle_a: assert property ( // [R24]
        tick |=> s_r.flash != $past(s_r.flash) ##1 $stable(s_r.flash))
        else $error("flash not toggling on tick");
    mod_major_a: assert property ( // [R12]
        s_r.ctrl[MAJOR_FAULT_BIT] && !s_r.ctrl[SELF_TEST_BIT] |=> MOD_RED && !MOD_GREEN)
        else $error("major fault not steady red");
    net_no_ip_a: assert property ( // [R20]
        !s_r.ctrl[IP_VALID_BIT] && !s_r.ctrl[SELF_TEST_BIT] |=> !NET_GREEN && !NET_RED)
        else $error("network indicator lit without address");
    link_follow_a: assert property ( // [R21]
        !RESET |=> LINK_GREEN == $past(LINK_UP))
        else $error("link indicator does not follow link");
    act_start_a: assert property ( // [R22]
        !RESET && s_r.act_cnt == '0 && FRAME_ACT |=> ##1 ACT_YELLOW)
        else $error("activity flash not started");

endmodule : sled_core

/* File: include/sled_pkg.sv */
// Constants shared by the front-panel status indicator block.
// Assumes a 125 MHz system clock and a classic Wishbone register bus with 32-bit data.
package sled_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int HALF_SEC_MS = 500;
    localparam int HALF_SEC_CYC = (CLK_HZ / 1000) * HALF_SEC_MS;
    localparam int ACT_FLASH_MS = 30;
    localparam int ACT_FLASH_CYC = (CLK_HZ / 1000) * ACT_FLASH_MS;
    localparam int DARK_TICKS = 4;
    localparam int SINGLE_TICKS = 5;
    localparam int DOUBLE_TICKS = 7;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
    localparam logic [31:0] STATE_ADDR = 32'h0000_0004;
    localparam int CTRL_W = 17;
    localparam logic [16:0] CTRL_RESET = 17'h0_0000;

    // Fields of the condition register written by firmware.
    localparam int OS_RUNNING_BIT = 0;
    localparam int BOOT_ERROR_BIT = 1;
    localparam int INIT_DONE_BIT = 2;
    localparam int GW_EXEC_BIT = 3;
    localparam int P1_CYCLIC_BIT = 4;
    localparam int P2_CYCLIC_BIT = 5;
    localparam int P1_CFG_ERR_BIT = 6;
    localparam int P2_CFG_ERR_BIT = 7;
    localparam int INIT_ERROR_BIT = 8;
    localparam int CONFIGURED_BIT = 9;
    localparam int MAJOR_FAULT_BIT = 10;
    localparam int MINOR_FAULT_BIT = 11;
    localparam int SELF_TEST_BIT = 12;
    localparam int CONNECTED_BIT = 13;
    localparam int IP_VALID_BIT = 14;
    localparam int DUP_IP_BIT = 15;
    localparam int CONN_TIMEOUT_BIT = 16;

    // Fields of the read-only indicator state register.
    localparam int LED_W = 10;
    localparam int SYS_GREEN_BIT = 0;
    localparam int SYS_YELLOW_BIT = 1;
    localparam int APP_GREEN_BIT = 2;
    localparam int APP_RED_BIT = 3;
    localparam int MOD_GREEN_BIT = 4;
    localparam int MOD_RED_BIT = 5;
    localparam int NET_GREEN_BIT = 6;
    localparam int NET_RED_BIT = 7;
    localparam int LINK_BIT = 8;
    localparam int ACT_BIT = 9;
    localparam int APP_MODE_LSB = 12;

    // Application indicator pattern, Gray coded along the start-up path.
    typedef enum logic [2:0] {
        SLED_APP_OFF = 3'b000,
        SLED_APP_RED_ON = 3'b001,
        SLED_APP_RED_1 = 3'b011,
        SLED_APP_RED_2 = 3'b010,
        SLED_APP_GRN_1 = 3'b110,
        SLED_APP_GRN_2 = 3'b111,
        SLED_APP_GRN_ON = 3'b101
    } sled_app_e;

endpackage : sled_pkg

/* File: verification/sled_panel.sv */
// Front-panel model: the duo indicator packages that the block drives.
// Assumes active-high pin drive, looked at on the rising clock edge.
`timescale 1ns/1ns
module sled_panel
(
    input wire logic clk,
    input wire logic sys_g,
    input wire logic sys_y,
    input wire logic app_g,
    input wire logic app_r,
    input wire logic mod_g,
    input wire logic mod_r,
    input wire logic net_g,
    input wire logic net_r,
    output int clash
);
    int cnt = 0;
    assign clash = cnt;
    // A duo package shows one colour at a time, so any cycle with both lit is counted.
    always @(posedge clk)
    begin
        if ((sys_g & sys_y) | (app_g & app_r) | (mod_g & mod_r) | (net_g & net_r))
        begin
            cnt <= cnt + 1;
        end
    end
endmodule : sled_panel

/* File: verification/sled_core_tb_top.sv */
// Self-checking bench for the indicator block, with an integer model of the patterns.
// Assumes short blink parameters: half second of 8 cycles, activity step of 2.
`timescale 1ns/1ns
module sled_core_tb_top;
    import sled_pkg::*;
    localparam int W = 560;
    logic clk, reset, cyc, stb, we, link_up, frame_act, ack;
    logic [31:0] adr, wdat, rdat, dat_o, seed, keep;
    logic [3:0] sel;
    logic sys_g, sys_y, app_g, app_r, mod_g, mod_r, net_g, net_r, link_g, act_y;
    int bad_count, checked, clash;

    sled_core #(.HALF_CYC(8), .ACT_CYC(2)) i_dut (.CLK(clk), .RESET(reset), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .LINK_UP(link_up), .FRAME_ACT(frame_act),
        .SYS_GREEN(sys_g), .SYS_YELLOW(sys_y), .APP_GREEN(app_g), .APP_RED(app_r),
        .MOD_GREEN(mod_g), .MOD_RED(mod_r), .NET_GREEN(net_g), .NET_RED(net_r),
        .LINK_GREEN(link_g), .ACT_YELLOW(act_y));
    sled_panel i_panel (.clk(clk), .sys_g(sys_g), .sys_y(sys_y), .app_g(app_g), .app_r(app_r),
        .mod_g(mod_g), .mod_r(mod_r), .net_g(net_g), .net_r(net_r), .clash(clash));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Lit cycles over W cycles, coded as green*1000+red (yellow for the system indicator).
    function automatic int exp_code(input logic [16:0] v, input int k);
        case (k)
            0: return v[BOOT_ERROR_BIT] ? 280280 : v[OS_RUNNING_BIT] ? 560000 : 560;
            1: return v[INIT_ERROR_BIT] ? 560 : !v[INIT_DONE_BIT] ? 0 : v[P1_CFG_ERR_BIT] ? 112 :
                v[P2_CFG_ERR_BIT] ? 160 : !v[P1_CYCLIC_BIT] ? 112000 : !v[P2_CYCLIC_BIT] ? 160000 :
                v[GW_EXEC_BIT] ? 560000 : 0;
            2: return v[SELF_TEST_BIT] ? 280280 : v[MAJOR_FAULT_BIT] ? 560 : v[MINOR_FAULT_BIT] ? 280 :
                v[CONFIGURED_BIT] ? 560000 : 280000;
            default: return v[SELF_TEST_BIT] ? 280280 : !v[IP_VALID_BIT] ? 0 : v[DUP_IP_BIT] ? 560 :
                v[CONN_TIMEOUT_BIT] ? 280 : v[CONNECTED_BIT] ? 560000 : 280000;
        endcase
    endfunction : exp_code

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %0h seen %0h", what, e, g);
            bad_count++;
        end
    endtask : chk

    task automatic wb(input logic w, input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        chk("bus ack", 1, ack);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic measure(input logic [16:0] c, input logic fa);
        int g[4];
        int r[4];
        int act;
        logic prev;
        g = '{default: 0};
        r = '{default: 0};
        act = 0;
        wb(1'b1, CTRL_ADDR, 4'hF, {15'h0, c});
        wb(1'b0, CTRL_ADDR, 4'hF, seed);
        chk("ctrl readback", {15'h0, c}, rdat);
        frame_act <= fa;
        repeat (8) @(posedge clk);
        prev = link_up;
        for (int i = 0; i < W; i++)
        begin
            @(posedge clk);
            chk("link indicator", prev, link_g);
            prev = link_up;
            link_up <= seed[0];
            seed = xs(seed);
            g[0] += (sys_g === 1'b1);
            r[0] += (sys_y === 1'b1);
            g[1] += (app_g === 1'b1);
            r[1] += (app_r === 1'b1);
            g[2] += (mod_g === 1'b1);
            r[2] += (mod_r === 1'b1);
            g[3] += (net_g === 1'b1);
            r[3] += (net_r === 1'b1);
            act += (act_y === 1'b1);
        end
        for (int k = 0; k < 4; k++)
        begin
            chk($sformatf("indicator %0d green", k), exp_code(c, k) / 1000, g[k]);
            chk($sformatf("indicator %0d red", k), exp_code(c, k) % 1000, r[k]);
        end
        chk("activity flashing", fa, (act > 0) && (act < W));
    endtask : measure

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end

    initial
    begin
        {reset, cyc, stb, we, link_up, frame_act} = 6'b100000;
        {adr, wdat, sel} = '0;
        seed = 32'h0000_314C;
        bad_count = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        wb(1'b0, CTRL_ADDR, 4'hF, 0);
        chk("ctrl reset", 0, rdat);
        keep = seed & 32'h0001_FFFF;
        wb(1'b1, CTRL_ADDR, 4'hF, seed);
        seed = xs(seed);
        wb(1'b1, CTRL_ADDR, 4'h1, seed);
        keep = {keep[31:8], seed[7:0]};
        wb(1'b1, STATE_ADDR, 4'hF, 32'hFFFF_FFFF);
        wb(1'b0, CTRL_ADDR, 4'hF, 0);
        chk("ctrl lanes", keep, rdat);
        wb(1'b0, 32'h0000_0008, 4'hF, 0);
        chk("unmapped read", 0, rdat);
        measure(17'h0_0000, 1'b0);
        measure(17'h0_623D, 1'b1);
        measure(17'h0_50E6, 1'b0);
        measure(17'h1_CC84, 1'b1);
        measure(17'h0_4215, 1'b0);
        measure(17'h0_2144, 1'b1);
        measure(17'h1_4A24, 1'b0);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        wb(1'b0, CTRL_ADDR, 4'hF, 0);
        chk("ctrl after reset", 0, rdat);
        wb(1'b0, STATE_ADDR, 4'hF, 0);
        chk("state after reset", 32'h0000_0002, rdat & 32'h0000_70CF);
        chk("duo clash", 0, clash);
        final_report();
    end
endmodule : sled_core_tb_top
